// ---- hw/clk_src_pkg.sv ----
// Package for the clock source selector: offsets, layouts, encodings
package clk_src_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ACTIVE = 8'h04;
   localparam logic [7:0] OFF_LOCK = 8'h08;
   localparam logic [7:0] OFF_MADI = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   // Input count and source codes
   localparam int N_IN = 5;
   localparam logic [2:0] SRC_WORD = 3'h0;
   localparam logic [2:0] SRC_MADI1 = 3'h1;
   localparam logic [2:0] SRC_MADI2 = 3'h2;
   localparam logic [2:0] SRC_MADI3 = 3'h3;
   localparam logic [2:0] SRC_AES = 3'h4;
   localparam logic [2:0] SRC_INT = 3'h7;
   // Control field positions
   localparam int CTRL_PREF_LSB = 0;
   localparam int CTRL_FIXED_BIT = 4;
   // Reset values
   localparam logic [2:0] PREF_RST = 3'h0;
   localparam logic [2:0] ACTIVE_RST = 3'h7;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // Interrupt bit positions
   localparam int IRQ_SWITCH = 0;
   localparam int IRQ_LOST = 1;
   localparam int IRQ_LOCKCHG = 2;
   // Lock state encoding
   typedef enum logic [1:0] {ST_NOLOCK = 2'b00, ST_LOCK = 2'b01, ST_SYNC = 2'b11} lock_state_e;
   // Per-MADI input format report
   typedef struct packed {
      logic [3:0] rate;
      logic frame_96k;
      logic ch56;
   } madi_fmt_s;
   // Switch sequencer states
   typedef enum logic [1:0] {SW_RUN = 2'b00, SW_GATE = 2'b01, SW_MUX = 2'b11} sw_state_e;
   localparam logic [3:0] GATE_CYC = 4'h4;
endpackage

// ---- hw/auto_clock_source_select.sv ----
// Automatic clock source selection with lock status and glitch-free switching
// Summary of operation
// [R01] Auto mode swaps internal oscillator for valid input
// [R02] Valid preferred input stays the reference
// [R03] Otherwise scan remaining inputs, take first valid
// [R04] No valid input: revert to internal master
// [R05] Report no lock, lock or sync per input
// [R06] Fixed internal mode ignores inputs for clocking
// [R07] MADI status adds rate, frame and channel format
// [R08] Source switching without runts or glitches
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module auto_clock_source_select
   import clk_src_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw per-input lock and sync detectors (asynchronous)
   input wire logic [N_IN-1:0] in_lock,
   input wire logic [N_IN-1:0] in_sync,
   // Raw MADI format indications (asynchronous)
   input wire madi_fmt_s [2:0] madi_fmt_in,
   // Clock gating and mux to the sample clock network
   output logic clk_gate_en,
   output logic [2:0] clk_mux_sel,
   output logic master_mode,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq
);
   logic [N_IN-1:0] lock_s1_r, lock_s2_r, sync_s1_r, sync_s2_r;
   madi_fmt_s [2:0] fmt_s1_r, fmt_s2_r, fmt_s3_r, fmt_r, fmt_nxt;
   logic [2:0] pref_r, pref_nxt;
   logic fixed_r, fixed_nxt;
   logic [2:0] active_r, active_nxt, mux_r, mux_nxt, target;
   sw_state_e sw_r, sw_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic [N_IN-1:0] lock_d_r;
   logic [31:0] prdata_r, prdata_nxt;
   lock_state_e [N_IN-1:0] lstate;
   logic wr_en, rd_en, addr_ok;

   // Two-flop synchronisers for lock and sync; the MADI format passes three flops
   always_ff @(posedge clk)
   begin
      lock_s1_r <= in_lock;
      lock_s2_r <= lock_s1_r;
      sync_s1_r <= in_sync;
      sync_s2_r <= sync_s1_r;
      fmt_s1_r <= madi_fmt_in;
      fmt_s2_r <= fmt_s1_r;
      fmt_s3_r <= fmt_s2_r;
   end

   // Format word moves only after two equal samples, so a read never mixes old and new bits
   always_comb
   begin
      fmt_nxt = fmt_r;
      if (fmt_s2_r == fmt_s3_r)
      begin
         fmt_nxt = fmt_s3_r; // [R07]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         fmt_r <= '0;
      end
      else
      begin
         fmt_r <= fmt_nxt;
      end
   end

   a_fmt_stable: assert property (@(posedge clk) disable iff (!rst_n) // [R07]
      $changed(fmt_r) |-> $past(fmt_s2_r) == $past(fmt_s3_r))
      else $error("Format taken while still moving");

   // Three-state report per input
   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++)
      begin : g_state
         assign lstate[gi] = !lock_s2_r[gi] ? ST_NOLOCK : (sync_s2_r[gi] ? ST_SYNC : ST_LOCK); // [R05]
         a_state_sync: assert property (@(posedge clk) disable iff (!rst_n) // [R05]
            lock_s2_r[gi] && sync_s2_r[gi] |-> lstate[gi] == ST_SYNC) else $error("Synchronous input not reported");
      end
   endgenerate

   // Source choice: preferred first, then the others in turn, else internal
   always_comb
   begin
      logic [2:0] idx;
      logic found;
      idx = '0;
      found = 1'b0;
      target = SRC_INT; // [R04]
      if (!fixed_r) // [R06]
      begin
         if (pref_r < 3'(N_IN) && lock_s2_r[pref_r])
         begin
            target = pref_r; // [R02] [R01]
         end
         else
         begin
            for (int k = 1; k <= N_IN; k++)
            begin
               idx = 3'((32'(pref_r) + k) % N_IN);
               if (!found && lock_s2_r[idx])
               begin
                  target = idx; // [R03]
                  found = 1'b1;
               end
            end
         end
      end
   end

   // Switch sequencer: gate clock, move mux, wait, ungate
   always_comb
   begin
      sw_nxt = sw_r;
      cnt_nxt = cnt_r;
      active_nxt = active_r;
      mux_nxt = mux_r;
      unique case (sw_r)
         SW_RUN:
         begin
            if (target != active_r)
            begin
               sw_nxt = SW_GATE; // [R08]
               cnt_nxt = GATE_CYC;
               active_nxt = target;
            end
         end
         SW_GATE:
         begin
            if (cnt_r == '0)
            begin
               mux_nxt = active_r; // [R08]
               sw_nxt = SW_MUX;
               cnt_nxt = GATE_CYC;
            end
            else
            begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         SW_MUX:
         begin
            if (cnt_r == '0)
            begin
               sw_nxt = SW_RUN;
            end
            else
            begin
               cnt_nxt = cnt_r - 4'h1;
            end
         end
         default:
         begin
            sw_nxt = SW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sw_r <= SW_RUN;
         cnt_r <= '0;
         active_r <= ACTIVE_RST;
         mux_r <= ACTIVE_RST;
         lock_d_r <= '0;
      end
      else
      begin
         sw_r <= sw_nxt;
         cnt_r <= cnt_nxt;
         active_r <= active_nxt;
         mux_r <= mux_nxt;
         lock_d_r <= lock_s2_r;
      end
   end

   assign clk_gate_en = (sw_r == SW_RUN); // [R08]
   assign clk_mux_sel = mux_r;
   assign master_mode = (mux_r == SRC_INT); // [R04]
   a_mux_active: assert property (@(posedge clk) disable iff (!rst_n) // [R01]
      sw_r == SW_RUN |-> mux_r == active_r) else $error("Idle mux differs from chosen source");
   a_fallback_master: assert property (@(posedge clk) disable iff (!rst_n) // [R04]
      sw_r == SW_RUN && target == SRC_INT && active_r != SRC_INT |-> ##6 master_mode)
      else $error("No fallback to internal master");

   // Events for the interrupt status
   always_comb
   begin
      ev = '0;
      ev[IRQ_SWITCH] = (sw_r == SW_RUN) && (target != active_r);
      ev[IRQ_LOST] = (active_r != SRC_INT) && (active_r < 3'(N_IN)) && !lock_s2_r[active_r];
      ev[IRQ_LOCKCHG] = (lock_d_r != lock_s2_r);
   end

   // APB: zero wait states, unmapped reads zero with error
   assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_ACTIVE) || (paddr == OFF_LOCK) ||
                    (paddr == OFF_MADI) || (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_MASK);
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_comb
   begin
      pref_nxt = pref_r;
      fixed_nxt = fixed_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      prdata_nxt = prdata_r;
      if (wr_en && paddr == OFF_CTRL)
      begin
         pref_nxt = pwdata[CTRL_PREF_LSB +: 3];
         fixed_nxt = pwdata[CTRL_FIXED_BIT];
      end
      if (wr_en && paddr == OFF_IRQ_MASK)
      begin
         mask_nxt = pwdata[2:0];
      end
      if (wr_en && paddr == OFF_IRQ_STAT)
      begin
         stat_nxt = stat_r & ~pwdata[2:0];
      end
      stat_nxt = stat_nxt | ev;
      if (rd_en)
      begin
         prdata_nxt = '0;
         unique case (paddr)
            OFF_CTRL: prdata_nxt = 32'({fixed_r, 1'b0, pref_r});
            OFF_ACTIVE: prdata_nxt = 32'({master_mode, mux_r});
            OFF_LOCK: prdata_nxt = 32'(lstate); // [R05]
            OFF_MADI: prdata_nxt = 32'(fmt_r); // [R07]
            OFF_IRQ_STAT: prdata_nxt = 32'(stat_r);
            OFF_IRQ_MASK: prdata_nxt = 32'(mask_r);
            default: prdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pref_r <= PREF_RST;
         fixed_r <= 1'b0;
         mask_r <= IRQ_RST;
         stat_r <= IRQ_RST;
         prdata_r <= '0;
      end
      else
      begin
         pref_r <= pref_nxt;
         fixed_r <= fixed_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign irq = |(stat_r & mask_r);
   a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && ev != '0 |=> (stat_r & $past(ev)) == $past(ev)) else $error("Status event lost");
   a_stat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n && !(wr_en && paddr == OFF_IRQ_STAT) |=> (stat_r & $past(stat_r)) == $past(stat_r))
      else $error("Status bit dropped without clear");

   a_fixed_internal: assert property (@(posedge clk) disable iff (!rst_n) // [R06]
      fixed_r |-> target == SRC_INT) else $error("Fixed mode chose an input");
   a_pref_kept: assert property (@(posedge clk) disable iff (!rst_n) // [R02]
      !fixed_r && pref_r < 3'(N_IN) && lock_s2_r[pref_r] |-> target == pref_r)
      else $error("Valid preferred input not chosen");
   a_none_internal: assert property (@(posedge clk) disable iff (!rst_n) // [R04]
      lock_s2_r == '0 |-> target == SRC_INT) else $error("No input valid but not internal");
   a_auto_adopt: assert property (@(posedge clk) disable iff (!rst_n) // [R01] [R03]
      !fixed_r && lock_s2_r != '0 |-> target != SRC_INT && lock_s2_r[target])
      else $error("Valid input not adopted");
   a_gate_switch: assert property (@(posedge clk) disable iff (!rst_n) // [R08]
      $changed(mux_r) |-> !clk_gate_en && !$past(clk_gate_en))
      else $error("Mux moved with clock ungated");
   a_switch_done: assert property (@(posedge clk) disable iff (!rst_n) // [R08]
      rst_n && sw_r == SW_RUN && target != active_r |=> !clk_gate_en [*5] ##1 !clk_gate_en [*5] ##1 clk_gate_en)
      else $error("Switch sequence wrong length");
   a_state_nolock: assert property (@(posedge clk) disable iff (!rst_n) // [R05]
      !lock_s2_r[0] |-> lstate[0] == ST_NOLOCK) else $error("Unlocked input reported locked");
   a_madi_fmt: assert property (@(posedge clk) disable iff (!rst_n) // [R07]
      rd_en && paddr == OFF_MADI |=> prdata[17:0] == $past(fmt_r))
      else $error("MADI format read wrong");
endmodule

// ---- dv/ext_src_model.sv ----
// Model of the external clock sources driving lock, sync and MADI format
`timescale 1ns/1ns
module ext_src_model
   import clk_src_pkg::*;
(
   // Clock
   input wire logic clk,
   // Wanted source states
   input wire logic [N_IN-1:0] lock_cfg,
   input wire logic [N_IN-1:0] sync_cfg,
   input wire madi_fmt_s [2:0] fmt_cfg,
   // Detector lines
   output logic [N_IN-1:0] in_lock,
   output logic [N_IN-1:0] in_sync,
   output madi_fmt_s [2:0] madi_fmt_in
);
   // A source is only synchronous while it is locked
   always_ff @(posedge clk)
   begin
      in_lock <= lock_cfg;
      in_sync <= lock_cfg & sync_cfg;
      madi_fmt_in <= fmt_cfg;
   end
endmodule

// ---- dv/test_auto_clock_source_select.sv ----
// Self-checking bench for the clock source selector
`timescale 1ns/1ns
module test_auto_clock_source_select;
   import clk_src_pkg::*;
   typedef struct {logic [4:0] lk; logic [4:0] sy; logic [2:0] pref; logic fx; logic [2:0] sel;} row_s;
   logic clk, rst_n, psel, penable, pwrite, clk_gate_en, master_mode, pready, pslverr, irq, gate_q, er;
   logic [4:0] lock_cfg, sync_cfg, in_lock, in_sync;
   madi_fmt_s [2:0] fmt_cfg, madi_fmt_in;
   logic [2:0] clk_mux_sel, sel_q;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, exp;
   int err_total, num_checks, cyc;
   // Lock, sync, preferred, fixed, expected source
   row_s rows[7] = '{'{5'h00, 5'h00, 3'h0, 1'b0, 3'h7}, '{5'h01, 5'h01, 3'h0, 1'b0, 3'h0},
      '{5'h16, 5'h04, 3'h0, 1'b0, 3'h1}, '{5'h16, 5'h10, 3'h3, 1'b0, 3'h4}, '{5'h03, 5'h02, 3'h3, 1'b0, 3'h0},
      '{5'h1f, 5'h1f, 3'h2, 1'b1, 3'h7}, '{5'h10, 5'h00, 3'h4, 1'b0, 3'h4}};

   ext_src_model src (.clk(clk), .lock_cfg(lock_cfg), .sync_cfg(sync_cfg), .fmt_cfg(fmt_cfg),
      .in_lock(in_lock), .in_sync(in_sync), .madi_fmt_in(madi_fmt_in));
   auto_clock_source_select dut (.clk(clk), .rst_n(rst_n), .in_lock(in_lock), .in_sync(in_sync),
      .madi_fmt_in(madi_fmt_in), .clk_gate_en(clk_gate_en), .clk_mux_sel(clk_mux_sel),
      .master_mode(master_mode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Mux may only move while the sample clock is gated off; also the run limit
   always @(posedge clk)
   begin
      if (rst_n === 1'b1 && clk_mux_sel !== sel_q && (gate_q !== 1'b0 || clk_gate_en !== 1'b0))
         chk("gate at mux change", 32'h0000_0000, 32'h0000_0001);
      sel_q <= clk_mux_sel;
      gate_q <= clk_gate_en;
      cyc++;
      if (cyc == 6000)
      begin
         err_total++;
         final_report();
      end
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {lock_cfg, sync_cfg, fmt_cfg} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk("reset mux", 32'h0000_003e, 32'({master_mode, clk_gate_en, clk_mux_sel, irq}));
      foreach (rows[i])
      begin
         lock_cfg <= rows[i].lk;
         sync_cfg <= rows[i].sy;
         apb(1'b1, OFF_CTRL, 32'({rows[i].fx, 1'b0, rows[i].pref}));
         repeat (30) @(posedge clk);
         chk("mux", 32'(rows[i].sel), 32'(clk_mux_sel));
         apb(1'b0, OFF_ACTIVE, 32'h0);
         chk("active", 32'({rows[i].sel == 3'h7, rows[i].sel}), rd);
         exp = '0;
         for (int k = 0; k < 5; k++)
            if (rows[i].lk[k])
               exp[2*k+:2] = rows[i].sy[k] ? 2'b11 : 2'b01;
         apb(1'b0, OFF_LOCK, 32'h0);
         chk("lock", exp, rd);
      end
      fmt_cfg <= 18'h2_c5a7;
      repeat (6) @(posedge clk);
      apb(1'b0, OFF_MADI, 32'h0);
      chk("madi", 32'h0002_c5a7, rd);
      apb(1'b1, OFF_IRQ_MASK, 32'h0000_0007);
      apb(1'b1, OFF_IRQ_STAT, 32'h0000_0007);
      lock_cfg <= 5'h00;
      repeat (30) @(posedge clk);
      chk("irq on", 32'h1, 32'(irq));
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("status", 32'h0000_0007, rd);
      chk("fallback", 32'h7, 32'(clk_mux_sel));
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      @(posedge clk);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, OFF_IRQ_MASK, 32'h0000_0007);
      apb(1'b1, OFF_IRQ_STAT, 32'h0000_0007);
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("status clear", 32'h0, rd);
      chk("irq clear", 32'h0, 32'(irq));
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0000_0001, {rd[30:0], er});
      lock_cfg <= 5'h01;
      repeat (30) @(posedge clk);
      chk("locked before reset", 32'h0, 32'(clk_mux_sel));
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("reset mid run", 32'h0000_003e, 32'({master_mode, clk_gate_en, clk_mux_sel, irq}));
      rst_n <= 1'b1;
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("ctrl after reset", 32'h0, rd);
      repeat (30) @(posedge clk);
      chk("relock after reset", 32'h0, 32'(clk_mux_sel));
      final_report();
   end
endmodule
